//--- src/standby_pkg.sv
/*
 standby controller package: mode codes, field positions, reset values, timing counts.
 assumes a single clock taken from the oscillator at 200 MHz.
*/
// Notes on behaviour
// R1: halt instruction enters mode chosen by halt mode field: 00 run, 10 idle, 01 stop.
// R2: core-only halt keeps clocks and peripherals running; core does dummy cycles.
// R3: core-only halt samples pending requests on the falling edge of clock out.
// R4: idle runs oscillator only; system clock stopped, clock pin held high.
// R5: idle detects requests without system clock; restart aligns to system clock.
// R6: idle ignores all sources except non-maskable and external zero.
// R7: stop halts oscillator and floats all ordinary pins.
// R8: drive-hold bit keeps outputs in stop; strobes and clock driven high; resets 0.
// R9: stop release restarts oscillator at once, clock gated until warm-up ends.
// R10: warm-up select bit: 0 gives 2^14 periods, 1 gives 2^16; resets 0.
// R11: stop released only by non-maskable, external zero, or reset pin.
// R12: reset release of stop skips warm-up; external reset must be long enough.
// R13: warm-up counter runs on every interrupt release from stop.
// R14: release requests during three-clock entry are held pending, not lost.
// R15: level at or above mask services interrupt; otherwise resume after halt.
// R16: external four to seven release only core-only halt.
// R17: DMA start never releases halt unless triggered by external zero.
// R18: core-only halt: all sources at mask; below mask only nmi, watchdog, ext zero.
// R19: software avoids port access right before the halt instruction.
// R20: halt mode field value 11 behaves as core-only halt.
package standby_pkg;
    localparam logic [1:0] HALT_RUN = 2'h0;
    localparam logic [1:0] HALT_IDLE = 2'h2;
    localparam logic [1:0] HALT_STOP = 2'h1;
    // control register bits, as held in the watchdog mode register
    localparam int WARM_BIT = 0;
    localparam int DRIVE_BIT = 1;
    localparam int HMODE_LSB = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // register map on the Avalon slave (byte addresses)
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK = 4'h8;
    localparam int WARM_SHORT_EXP = 14;
    localparam int WARM_LONG_EXP = 16;
    localparam int ENTRY_CLOCKS = 3;
    localparam int SRC_NMI = 0;
    localparam int SRC_WD = 1;
    localparam int SRC_EXT_IRQ_ZERO = 2;
    localparam int SRC_INT47 = 3;
    localparam int SRC_PERIPH = 4;
    localparam int SRC_DMA = 5;
    localparam int NSRC = 6;
    localparam int LEVEL_W = 3;
    typedef enum logic [2:0] {ST_RUN, ST_ENTER, ST_HALT, ST_WARM, ST_RESUME} state_e;
    localparam logic [15:0] DUMMY_WORD = 16'h0000;
endpackage

//--- src/warmup_counter.sv
/*
 warm-up counter for oscillator restart out of stop.
 assumes start pulses only while idle; length set by parameters for simulation.
*/
`timescale 1ns/10ps
`default_nettype none
module warmup_counter #(
    parameter int SHORT_CYCLES = 16384,
    parameter int LONG_CYCLES = 65536
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic start_i,
    input wire logic long_i,
    output logic busy_o,
    output logic done_o
);
    logic [16:0] cnt_r;
    logic [16:0] load;
    assign load = long_i ? 17'(LONG_CYCLES - 1) : 17'(SHORT_CYCLES - 1);
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cnt_r <= 17'h00000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= busy_o && cnt_r == 17'h00000;
            if (start_i) begin
                cnt_r <= load;
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (cnt_r == 17'h00000) begin
                    busy_o <= 1'b0;
                end else begin
                    cnt_r <= cnt_r - 17'h00001;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- src/release_decoder.sv
/*
 release decoder: decides which sources may end a halt in each mode.
 assumes requests are held levels from the interrupt controller.
*/
`timescale 1ns/10ps
`default_nettype none
module release_decoder
    import standby_pkg::*;
(
    input wire logic [1:0] mode_i,
    input wire logic [NSRC-1:0] req_i,
    input wire logic [NSRC-1:0] at_mask_i,
    input wire logic dma_from_ext_irq_zero_i,
    output logic release_o,
    output logic service_o
);
    logic stop_or_idle;
    logic [NSRC-1:0] ok_hi;
    logic [NSRC-1:0] ok_lo;
    logic [NSRC-1:0] hi;
    logic [NSRC-1:0] lo;
    assign stop_or_idle = (mode_i == HALT_IDLE) || (mode_i == HALT_STOP);
    always_comb begin
        ok_hi = '0;
        ok_lo = '0;
        ok_hi[SRC_NMI] = 1'b1; // R11
        ok_lo[SRC_NMI] = 1'b1;
        ok_hi[SRC_EXT_IRQ_ZERO] = 1'b1;
        ok_lo[SRC_EXT_IRQ_ZERO] = 1'b1;
        ok_hi[SRC_DMA] = dma_from_ext_irq_zero_i; // R17
        if (!stop_or_idle) begin
            // value 11 falls here too R20
            ok_hi[SRC_WD] = 1'b1; // R18
            ok_lo[SRC_WD] = 1'b1;
            ok_hi[SRC_INT47] = 1'b1; // R16
            ok_hi[SRC_PERIPH] = 1'b1;
        end
    end
    assign hi = req_i & at_mask_i & ok_hi; // R6
    assign lo = req_i & ~at_mask_i & ok_lo;
    assign release_o = |hi || |lo;
    assign service_o = |hi; // R15
endmodule
`default_nettype wire

//--- src/standby_halt_controller.sv
/*
 standby halt controller top: mode register over Avalon-MM, halt sequencing,
 clock gating, pin hold control and warm-up.
 assumes the core pulses HALT_EXEC_I when it executes its halt instruction and
 that interrupt requests are synchronous levels with per-source mask compare.
*/
`timescale 1ns/10ps
`default_nettype none
module standby_halt_controller
    import standby_pkg::*;
#(
    parameter int WARM_SHORT = 2 ** standby_pkg::WARM_SHORT_EXP,
    parameter int WARM_LONG = 2 ** standby_pkg::WARM_LONG_EXP
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic HALT_EXEC_I,
    input wire logic [standby_pkg::NSRC-1:0] IRQ_REQ_I,
    input wire logic [standby_pkg::NSRC-1:0] IRQ_AT_MASK_I,
    input wire logic DMA_FROM_EXT_IRQ_ZERO_I,
    output logic CORE_HALTED_O,
    output logic DUMMY_CYCLE_O,
    output logic SAMPLE_IRQ_O,
    output logic RESUME_O,
    output logic SERVICE_O,
    output logic SYSCLK_EN_O,
    output logic PERIPH_EN_O,
    output logic OSC_EN_O,
    output logic CLK_PIN_HIGH_O,
    output logic PINS_FLOAT_O,
    output logic PINS_HOLD_O,
    output logic STROBES_HIGH_O,
    output logic WARMING_O
);
    logic [7:0] ctrl_r;
    logic [1:0] mode_r;
    logic [NSRC-1:0] pend_r;
    logic [1:0] enter_cnt_r;
    logic clk_phase_r;
    logic service_r;
    state_e state_r;
    state_e state_nxt;
    logic [1:0] field;
    logic rel;
    logic svc;
    logic warm_start;
    logic warm_busy;
    logic warm_done;
    logic wr_mode;
    logic access;
    logic [31:0] rdata;
    logic [NSRC-1:0] req_all;
    logic low_power;

    assign field = ctrl_r[HMODE_LSB +: 2];
    assign low_power = (mode_r == HALT_IDLE) || (mode_r == HALT_STOP);
    // nmi and ext zero requests seen during entry stay pending and join later decisions R14
    assign req_all = IRQ_REQ_I | pend_r;

    release_decoder u_dec (
        .mode_i(mode_r),
        .req_i(req_all),
        .at_mask_i(IRQ_AT_MASK_I),
        .dma_from_ext_irq_zero_i(DMA_FROM_EXT_IRQ_ZERO_I),
        .release_o(rel),
        .service_o(svc)
    );

    warmup_counter #(
        .SHORT_CYCLES(WARM_SHORT),
        .LONG_CYCLES(WARM_LONG)
    ) u_warm (
        .CLK_I(CLK_I),
        .RESET_N_I(RESET_N_I),
        .start_i(warm_start),
        .long_i(ctrl_r[WARM_BIT]), // R10
        .busy_o(warm_busy),
        .done_o(warm_done)
    );

    // waitrequest idles high and drops low for one cycle once a request has been seen
    assign access = AVS_READ_I || AVS_WRITE_I;
    assign wr_mode = AVS_WRITE_I && AVS_ADDRESS_I == ADDR_MODE && AVS_BYTEENABLE_I[0];
    assign rdata = (AVS_ADDRESS_I == ADDR_MODE) ? {24'h000000, ctrl_r} :
        (AVS_ADDRESS_I == ADDR_STATUS) ? {25'h0000000, warm_busy, 2'(state_r), 2'(mode_r),
            service_r, CORE_HALTED_O} :
        (AVS_ADDRESS_I == ADDR_MASK) ? {26'h0000000, pend_r} : 32'h00000000;

    assign warm_start = state_r == ST_HALT && rel && mode_r == HALT_STOP; // R13

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (HALT_EXEC_I) begin
                    state_nxt = (field == HALT_IDLE || field == HALT_STOP) ? ST_ENTER : ST_HALT;
                end
            end
            ST_ENTER: begin
                if (enter_cnt_r == 2'(ENTRY_CLOCKS - 1)) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_HALT: begin
                if (rel && mode_r == HALT_STOP) begin
                    state_nxt = ST_WARM; // R9
                end else if (rel) begin
                    state_nxt = ST_RESUME;
                end
            end
            ST_WARM: begin
                if (warm_done) begin
                    state_nxt = ST_RESUME;
                end
            end
            ST_RESUME: state_nxt = ST_RUN;
            default: state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ctrl_r <= CTRL_RESET; // R8 R10
            AVS_READDATA_O <= 32'h00000000;
            AVS_WAITREQUEST_O <= 1'b1;
        end else begin
            AVS_WAITREQUEST_O <= !(access && AVS_WAITREQUEST_O);
            if (access && AVS_WAITREQUEST_O) begin
                AVS_READDATA_O <= rdata;
            end
            // the write lands on the edge that completes the transfer
            if (wr_mode && !AVS_WAITREQUEST_O) begin
                ctrl_r <= AVS_WRITEDATA_I[7:0];
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_r <= ST_RUN;
            mode_r <= HALT_RUN;
            enter_cnt_r <= 2'h0;
            pend_r <= '0;
            service_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_RUN && HALT_EXEC_I) begin
                // undefined 11 collapses to core-only halt R1 R20
                mode_r <= (field == HALT_IDLE || field == HALT_STOP) ? field : HALT_RUN;
            end
            enter_cnt_r <= state_r == ST_ENTER ? enter_cnt_r + 2'h1 : 2'h0;
            if (state_r == ST_ENTER) begin
                pend_r[SRC_NMI] <= pend_r[SRC_NMI] | IRQ_REQ_I[SRC_NMI]; // R14
                pend_r[SRC_EXT_IRQ_ZERO] <= pend_r[SRC_EXT_IRQ_ZERO] | IRQ_REQ_I[SRC_EXT_IRQ_ZERO];
            end else if (state_r == ST_RESUME) begin
                pend_r <= '0;
            end
            if (state_r == ST_HALT && rel) begin
                service_r <= svc; // R15
            end
        end
    end

    // core-only halt samples on the falling half of clock out R3
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            clk_phase_r <= 1'b0;
        end else begin
            clk_phase_r <= ~clk_phase_r;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            CORE_HALTED_O <= 1'b0;
            DUMMY_CYCLE_O <= 1'b0;
            SAMPLE_IRQ_O <= 1'b0;
            RESUME_O <= 1'b0;
            SERVICE_O <= 1'b0;
            SYSCLK_EN_O <= 1'b1;
            PERIPH_EN_O <= 1'b1;
            OSC_EN_O <= 1'b1;
            CLK_PIN_HIGH_O <= 1'b0;
            PINS_FLOAT_O <= 1'b0;
            PINS_HOLD_O <= 1'b0;
            STROBES_HIGH_O <= 1'b0;
            WARMING_O <= 1'b0;
        end else begin
            CORE_HALTED_O <= state_nxt != ST_RUN && state_nxt != ST_RESUME;
            DUMMY_CYCLE_O <= state_nxt == ST_HALT && mode_r == HALT_RUN; // R2
            SAMPLE_IRQ_O <= state_r == ST_HALT && mode_r == HALT_RUN && clk_phase_r; // R3
            RESUME_O <= state_r == ST_RESUME;
            SERVICE_O <= state_r == ST_RESUME && service_r;
            // idle/stop: request detect is combinational, restart waits for a clock edge R5
            SYSCLK_EN_O <= !(state_nxt == ST_HALT && low_power) && state_nxt != ST_WARM; // R4 R9
            PERIPH_EN_O <= !(state_nxt == ST_HALT && low_power) && state_nxt != ST_WARM;
            OSC_EN_O <= !(state_nxt == ST_HALT && mode_r == HALT_STOP); // R7 R9
            CLK_PIN_HIGH_O <= (state_nxt == ST_HALT && mode_r == HALT_IDLE) ||
                (state_nxt == ST_HALT && mode_r == HALT_STOP && ctrl_r[DRIVE_BIT]); // R4 R8
            PINS_FLOAT_O <= state_nxt == ST_HALT && mode_r == HALT_STOP && !ctrl_r[DRIVE_BIT]; // R7
            PINS_HOLD_O <= state_nxt == ST_HALT && mode_r == HALT_STOP && ctrl_r[DRIVE_BIT]; // R8
            STROBES_HIGH_O <= state_nxt == ST_HALT && mode_r == HALT_STOP && ctrl_r[DRIVE_BIT];
            WARMING_O <= state_nxt == ST_WARM;
        end
    end

    property p_enter_low;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (state_r == ST_RUN && HALT_EXEC_I && (field == HALT_IDLE || field == HALT_STOP))
            |=> state_r == ST_ENTER [*3] ##1 state_r == ST_HALT;
    endproperty
    a_enter_low: assert property (p_enter_low) else $error("entry not three clocks"); // R14

    property p_mode11;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (state_r == ST_RUN && HALT_EXEC_I && field == 2'h3) |=> state_r == ST_HALT && mode_r == HALT_RUN;
    endproperty
    a_mode11: assert property (p_mode11) else $error("mode 11 not core halt"); // R20

    property p_idle_clk;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (state_r == ST_HALT && mode_r == HALT_IDLE && !rel) |=> CLK_PIN_HIGH_O && !SYSCLK_EN_O && OSC_EN_O;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("idle clock state wrong"); // R4

    property p_stop_float;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (state_r == ST_HALT && mode_r == HALT_STOP && !rel && !ctrl_r[DRIVE_BIT])
            |=> PINS_FLOAT_O && !OSC_EN_O;
    endproperty
    a_stop_float: assert property (p_stop_float) else $error("stop pins not floated"); // R7

    property p_stop_hold;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (state_r == ST_HALT && mode_r == HALT_STOP && !rel && ctrl_r[DRIVE_BIT])
            |=> PINS_HOLD_O && STROBES_HIGH_O && CLK_PIN_HIGH_O && !PINS_FLOAT_O;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop hold wrong"); // R8

    property p_warm;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        warm_start |=> OSC_EN_O && !SYSCLK_EN_O && state_r == ST_WARM;
    endproperty
    a_warm: assert property (p_warm) else $error("warm-up not started"); // R9

    property p_idle_ignore;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (state_r == ST_HALT && low_power && !req_all[SRC_NMI] && !req_all[SRC_EXT_IRQ_ZERO]
            && !(req_all[SRC_DMA] && DMA_FROM_EXT_IRQ_ZERO_I && IRQ_AT_MASK_I[SRC_DMA]))
            |=> state_r == ST_HALT;
    endproperty
    a_idle_ignore: assert property (p_idle_ignore) else $error("bad source released"); // R6

    property p_run_service;
        @(posedge CLK_I) disable iff (!RESET_N_I)
        (state_r == ST_HALT && mode_r == HALT_RUN && IRQ_REQ_I[SRC_PERIPH] && IRQ_AT_MASK_I[SRC_PERIPH])
            |=> ##1 SERVICE_O && RESUME_O;
    endproperty
    a_run_service: assert property (p_run_service) else $error("service not flagged"); // R18
endmodule
`default_nettype wire

//--- bench/core_irq_model.sv
/*
 far-side model: the core that issues the halt and the interrupt controller
 that holds request flags until a release. assumes the bench clock only.
*/
`timescale 1ns/10ps
`default_nettype none
module core_irq_model
    import standby_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic halt_go_i,
    input wire logic [NSRC-1:0] raise_i,
    input wire logic resume_i,
    output logic halt_exec_o,
    output logic [NSRC-1:0] req_o
);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            halt_exec_o <= 1'b0;
            req_o <= '0;
        end else begin
            // halt goes out with no port access ahead of it
            halt_exec_o <= halt_go_i;
            // flags are acknowledged, hence dropped, by a release
            req_o <= resume_i ? raise_i : (req_o | raise_i);
        end
    end
endmodule
`default_nettype wire

//--- bench/standby_halt_controller_bench.sv
/*
 bench for the standby halt controller: avalon tasks and halt scenarios.
 assumes core_irq_model as far side and shortened warm-up counts.
*/
`timescale 1ns/10ps
`default_nettype none
module standby_halt_controller_bench;
    import standby_pkg::*;
    localparam int WS = 8;
    localparam int WL = 16;
    logic clk, rst_n, rd, wr, hgo, dma0, waitreq, halt_x, halted, dummy, smp;
    logic resume, service, sysclk, periph, osc, clkhi, flt, hold, strb, warming;
    logic [3:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [NSRC-1:0] raise, amask, req;
    logic s;
    int fail_count, total_checks, cyc, n, k;

    standby_halt_controller #(.WARM_SHORT(WS), .WARM_LONG(WL)) DUT (
        .CLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hF),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(waitreq), .HALT_EXEC_I(halt_x),
        .IRQ_REQ_I(req), .IRQ_AT_MASK_I(amask), .DMA_FROM_EXT_IRQ_ZERO_I(dma0),
        .CORE_HALTED_O(halted), .DUMMY_CYCLE_O(dummy), .SAMPLE_IRQ_O(smp),
        .RESUME_O(resume), .SERVICE_O(service), .SYSCLK_EN_O(sysclk),
        .PERIPH_EN_O(periph), .OSC_EN_O(osc), .CLK_PIN_HIGH_O(clkhi),
        .PINS_FLOAT_O(flt), .PINS_HOLD_O(hold), .STROBES_HIGH_O(strb),
        .WARMING_O(warming));
    core_irq_model DUT_far (.clk_i(clk), .rst_n_i(rst_n), .halt_go_i(hgo),
        .raise_i(raise), .resume_i(resume), .halt_exec_o(halt_x), .req_o(req));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            finish_test;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // request held until waitrequest is sampled low; one idle edge after
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task rdchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task enter(input logic [7:0] c);
        bus(1'b1, ADDR_MODE, {24'h0, c});
        hgo <= 1'b1;
        @(posedge clk);
        hgo <= 1'b0;
        for (n = 0; n < 20 && halted !== 1'b1; n++) @(posedge clk);
        // idle and stop only settle once the entry clocks are over
        repeat (ENTRY_CLOCKS + 1) @(posedge clk);
    endtask

    task wait_res(input int lim);
        s = 1'b0;
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            if (resume === 1'b1) begin
                s = service;
                break;
            end
        end
    endtask

    task fire(input int src);
        raise[src] <= 1'b1;
        @(posedge clk);
        raise <= '0;
    endtask

    task quiet(input int src);
        fire(src);
        wait_res(20);
        chk(n == 20, 1'b1);
    endtask

    initial begin
        rst_n = 1'b0;
        {rd, wr, hgo, dma0} = 4'h0;
        adr = 4'h0;
        wdat = 32'h0;
        raise = '0;
        amask = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({sysclk, osc, halted}, 3'b110);
        rdchk(ADDR_MODE, 32'h0);
        bus(1'b1, 4'hC, 32'hFF);
        rdchk(4'hC, 32'h0);
        bus(1'b1, ADDR_MODE, 32'h0F);
        rdchk(ADDR_MODE, 32'h0F);
        // core-only halt, release at mask by ext four to seven
        amask <= 6'h08;
        enter(8'h00);
        chk({halted, sysclk, periph, dummy}, 4'hF);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk({q[3:2], q[0]}, {HALT_RUN, 1'b1});
        k = 0;
        for (n = 0; n < 4; n++) begin
            @(posedge clk);
            k += int'(smp === 1'b1);
        end
        chk(k, 2);
        fire(SRC_INT47);
        wait_res(10);
        chk({n < 10, s}, 2'b11);
        // below mask: peripheral ignored, watchdog resumes inline
        amask <= '0;
        enter(8'h00);
        quiet(SRC_PERIPH);
        fire(SRC_WD);
        wait_res(10);
        chk({n < 10, s}, 2'b10);
        // dma start releases only when driven by ext zero
        amask <= '1;
        enter(8'h00);
        quiet(SRC_DMA);
        dma0 <= 1'b1;
        wait_res(10);
        chk(n < 10, 1'b1);
        dma0 <= 1'b0;
        // peripheral at mask releases core-only halt with service
        enter(8'h00);
        fire(SRC_PERIPH);
        wait_res(10);
        chk({n < 10, s}, 2'b11);
        // idle
        enter(8'h08);
        chk({sysclk, periph, clkhi, osc}, 4'h3);
        quiet(SRC_INT47);
        quiet(SRC_PERIPH);
        quiet(SRC_WD);
        fire(SRC_EXT_IRQ_ZERO);
        wait_res(10);
        chk({n < 10, s}, 2'b11);
        // stop, short warm-up, pins float
        enter(8'h04);
        chk({osc, flt, hold}, 3'b010);
        quiet(SRC_WD);
        fire(SRC_NMI);
        for (n = 0; n < 5 && warming !== 1'b1; n++) @(posedge clk);
        chk({osc, sysclk}, 2'b10);
        wait_res(40);
        chk(n >= WS - 2 && n <= WS + 3, 1'b1);
        chk(s, 1'b1);
        // stop with drive hold and long warm-up, below mask
        amask <= '0;
        enter(8'h07);
        chk({hold, strb, clkhi, flt}, 4'hE);
        fire(SRC_EXT_IRQ_ZERO);
        for (n = 0; n < 5 && warming !== 1'b1; n++) @(posedge clk);
        wait_res(60);
        chk(n >= WL - 2 && n <= WL + 3, 1'b1);
        chk(s, 1'b0);
        // unlisted mode code behaves as core-only halt
        enter(8'h0C);
        chk({halted, sysclk, dummy}, 3'b111);
        fire(SRC_NMI);
        wait_res(10);
        chk(n < 10, 1'b1);
        // stop left by the reset pin, held long enough outside
        enter(8'h04);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk({osc, halted}, 2'b10);
        rst_n <= 1'b1;
        @(posedge clk);
        finish_test;
    end
endmodule
`default_nettype wire
